// [lsc_pkg.sv]
// Purpose: shared constants and types of the load setting command engine
// Assumes: levels are unsigned integers in micro-units of their quantity
// Notes: register byte offsets, command word layout and status fields live here
package lsc_pkg;
   localparam int unsigned LSC_AW = 8;
   localparam logic [LSC_AW-1:0] LSC_ADDR_CMD = 8'h00;
   localparam logic [LSC_AW-1:0] LSC_ADDR_VALUE = 8'h04;
   localparam logic [LSC_AW-1:0] LSC_ADDR_STATUS = 8'h08;
   localparam logic [LSC_AW-1:0] LSC_ADDR_SINK = 8'h0c;
   localparam logic [LSC_AW-1:0] LSC_ADDR_THRESH = 8'h10;
   localparam logic [1:0] LSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] LSC_RESP_SLVERR = 2'h2;
   localparam logic [3:0] LSC_STRB_ALL = 4'hf;
   // one step of the sink thresholds, 0.1 V in microvolts
   localparam logic [31:0] LSC_STEP_UV = 32'h000186a0;
   localparam logic [7:0] LSC_START_RST = 8'h0a;
   localparam logic [7:0] LSC_STOP_RST = 8'h05;
   localparam logic [7:0] LSC_TENTHS_MIN = 8'h01;
   localparam logic [7:0] LSC_TENTHS_MAX = 8'hfa;
   localparam logic [3:0] LSC_STATES = 4'h5;
   localparam logic [4:0] LSC_BANKS = 5'h1e;
   localparam int unsigned LSC_NSLOT = 150;
   localparam logic [3:0] LSC_ARG_MAX_BOOL = 4'h1;
   localparam logic [3:0] LSC_ARG_MAX_MODE = 4'h3;
   localparam int unsigned LSC_ERR_NO_POINT = 0;
   localparam int unsigned LSC_ERR_RANGE = 1;
   localparam int unsigned LSC_ERR_ARG = 2;
   localparam int unsigned LSC_ST_TRIP_LSB = 8;
   localparam int unsigned LSC_ST_MODE_LSB = 16;
   localparam int unsigned LSC_TH_STOP_LSB = 8;
   localparam int unsigned LSC_SINK_LOAD_LSB = 16;

   typedef enum logic [1:0]
   {
      CONSTANT_CURRENT_MODE = 2'h0,
      CONSTANT_RESISTANCE_MODE = 2'h1,
      CONSTANT_VOLTAGE_MODE = 2'h2,
      CONSTANT_POWER_MODE = 2'h3
   } lsc_mode_t;

   typedef enum logic [4:0]
   {
      OP_NONE, OP_LEVEL_CURRENT, OP_LEVEL_RESISTANCE, OP_LEVEL_VOLTAGE, OP_LEVEL_POWER, OP_LOAD,
      OP_SINK_START_VOLTAGE, OP_SINK_STOP_VOLTAGE, OP_HIGH_LOW_SELECT,
      OP_SHOW_PROGRAMMED_SETTING, OP_MODE, OP_STATUS_WIPE_COMMAND,
      OP_SAVE_STATE_COMMAND, OP_RESTORE_SAVED_STATE_COMMAND
   } lsc_op_t;

   typedef struct packed
   {
      logic [6:0] unused;
      logic [4:0] bank;
      logic [3:0] state;
      logic [3:0] arg;
      logic from_serial;
      logic [2:0] chan;
      logic all_channel_prefix;
      logic point;
      logic high;
      lsc_op_t op;
   } lsc_cmd_t;

   typedef logic [1:0][31:0] lsc_pair_t;

   typedef struct packed
   {
      lsc_pair_t [3:0] lvl;
      logic load_on;
      logic high_sel;
      logic show_prog;
   } lsc_chan_t;
endpackage : lsc_pkg

// [lsc_engine.sv]
// Purpose: command engine keeping the programmed state of a multi-channel DC load
// Assumes: commands arrive pre-tokenised over AXI4-Lite; MEAS_UV and TRIP_EVENT come from same-clock logic
// Notes: a write to the command register executes in the cycle the write completes
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module lsc_engine
   import lsc_pkg::*;
#(
   parameter int unsigned NCH = 8,
   parameter logic [31:0] FS_CURR = 32'h03938700,
   parameter logic [31:0] FS_RES = 32'h3b9aca00,
   parameter logic [31:0] FS_VOLT = 32'h0b2d05e0,
   parameter logic [31:0] FS_POW = 32'h3b9aca00
)
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [LSC_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [LSC_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [NCH*32-1:0] MEAS_UV,
   input wire logic [7:0] TRIP_EVENT,
   output logic [NCH*32-1:0] SETPOINT,
   output logic [1:0] MODE,
   output logic [NCH-1:0] LOAD_ON,
   output logic [NCH-1:0] SINK_ACTIVE,
   output logic [NCH-1:0] SHOW_PROGRAMMED
);
   logic aw_full_reg;
   logic w_full_reg;
   logic [LSC_AW-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [31:0] value_reg;
   logic [31:0] cmd_reg;
   lsc_mode_t mode_reg;
   logic [7:0] start_reg;
   logic [7:0] stop_reg;
   logic [7:0] err_reg;
   logic [7:0] trip_reg;
   lsc_chan_t slot_mem [LSC_NSLOT];
   wire lsc_chan_t [NCH-1:0] chan_all;

   // write channel: address and data latched independently, then joined
   wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   wire wr_cmd = awaddr_reg == LSC_ADDR_CMD;
   wire wr_value = awaddr_reg == LSC_ADDR_VALUE;
   // partial writes to the command word are refused so no half command runs
   wire exec = do_write && wr_cmd && (wstrb_reg == LSC_STRB_ALL);
   wire wr_ok = exec || (do_write && wr_value);
   wire [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

   assign S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
   assign S_AXI_WREADY = !w_full_reg && !bvalid_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RRESP = rresp_reg;
   assign S_AXI_RDATA = rdata_reg;

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg <= LSC_RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_full_reg <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR;
         end
         else if (do_write)
            aw_full_reg <= 1'b0;
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_full_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
         end
         else if (do_write)
            w_full_reg <= 1'b0;
         if (do_write)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? LSC_RESP_OKAY : LSC_RESP_SLVERR;
         end
         else if (S_AXI_BREADY)
            bvalid_reg <= 1'b0;
      end
   end

   // command decode; the serial/bus source bit is deliberately not looked at
   wire lsc_cmd_t cmd = lsc_cmd_t'(wdata_reg);
   wire logic [4:0] op_bits = cmd.op;
   wire is_level = (op_bits >= OP_LEVEL_CURRENT) && (op_bits <= OP_LEVEL_POWER);
   wire is_start = cmd.op == OP_SINK_START_VOLTAGE;
   wire is_stop = cmd.op == OP_SINK_STOP_VOLTAGE;
   wire is_save = cmd.op == OP_SAVE_STATE_COMMAND;
   wire is_restore = cmd.op == OP_RESTORE_SAVED_STATE_COMMAND;
   wire is_bool = (cmd.op == OP_LOAD) || (cmd.op == OP_HIGH_LOW_SELECT) || (cmd.op == OP_SHOW_PROGRAMMED_SETTING);
   wire logic [1:0] lvl_mode = 2'(op_bits - 5'(OP_LEVEL_CURRENT));
   // value_reg counts micro-amperes, micro-ohms, microvolts or microwatts by opcode
   wire logic [31:0] fs_sel = (lvl_mode == CONSTANT_CURRENT_MODE) ? FS_CURR :
      (lvl_mode == CONSTANT_RESISTANCE_MODE) ? FS_RES :
      (lvl_mode == CONSTANT_VOLTAGE_MODE) ? FS_VOLT : FS_POW;
   wire logic [31:0] val_fs = (value_reg > fs_sel) ? fs_sel : value_reg;

   // thresholds must be whole 0.1 V steps; anything else is refused
   wire logic [31:0] tenths = value_reg / LSC_STEP_UV;
   wire step_ok = (64'(tenths) * 64'(LSC_STEP_UV)) == 64'(value_reg);
   wire start_ok = step_ok && (tenths >= 32'(LSC_TENTHS_MIN)) && (tenths <= 32'(LSC_TENTHS_MAX));
   wire stop_ok = step_ok && (tenths >= 32'(LSC_TENTHS_MIN)) && (tenths <= 32'(start_reg));

   // omitted bank means bank 1
   wire logic [4:0] bank_eff = (cmd.bank == 5'h00) ? 5'h01 : cmd.bank;
   wire logic [7:0] slot_num = 8'(8'(bank_eff - 5'h01) * 8'(LSC_STATES)) + 8'(cmd.state);
   wire logic [7:0] slot_addr = slot_num - 8'h01;
   wire slot_ok = (cmd.state != 4'h0) && (cmd.state <= LSC_STATES) && (bank_eff <= LSC_BANKS);

   wire chan_bad = !cmd.all_channel_prefix && (32'(cmd.chan) >= NCH);
   wire no_point = (is_level || is_start || is_stop) && !cmd.point;
   wire range_bad = (is_start && !start_ok) || (is_stop && !stop_ok) || ((is_save || is_restore) && !slot_ok);
   wire op_bad = (cmd.op == OP_NONE) || (op_bits > OP_RESTORE_SAVED_STATE_COMMAND);
   wire arg_bad = chan_bad || op_bad || (is_bool && (cmd.arg > LSC_ARG_MAX_BOOL)) ||
      ((cmd.op == OP_MODE) && (cmd.arg > LSC_ARG_MAX_MODE));
   wire rejected = no_point || range_bad || arg_bad;
   wire accept = exec && !rejected;
   wire wipe = accept && (cmd.op == OP_STATUS_WIPE_COMMAND);
   wire logic [7:0] err_set = exec ? ((8'(no_point) << LSC_ERR_NO_POINT) | (8'(range_bad) << LSC_ERR_RANGE) |
      (8'(arg_bad) << LSC_ERR_ARG)) : 8'h00;
   // a new event in the wipe cycle survives the wipe
   wire logic [7:0] err_next = (wipe ? 8'h00 : err_reg) | err_set;
   wire logic [7:0] trip_next = (wipe ? 8'h00 : trip_reg) | TRIP_EVENT;
   wire lsc_chan_t slot_rd = slot_ok ? slot_mem[slot_addr] : '0;
   wire lsc_chan_t save_src = chan_bad ? '0 : chan_all[cmd.chan];

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         value_reg <= '0;
         cmd_reg <= '0;
         mode_reg <= CONSTANT_CURRENT_MODE;
         start_reg <= LSC_START_RST;
         stop_reg <= LSC_STOP_RST;
         err_reg <= '0;
         trip_reg <= '0;
      end
      else
      begin
         if (do_write && wr_value)
            value_reg <= (value_reg & ~strb_mask) | (wdata_reg & strb_mask);
         if (exec)
            cmd_reg <= wdata_reg;
         if (accept && (cmd.op == OP_MODE))
            mode_reg <= lsc_mode_t'(cmd.arg[1:0]);
         if (accept && is_start)
            start_reg <= tenths[7:0];
         if (accept && is_stop)
            stop_reg <= tenths[7:0];
         err_reg <= err_next;
         trip_reg <= trip_next;
      end
   end

   // slots sit in flip-flops; cleared at reset so an unsaved slot restores zeros
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         for (int s = 0; s < LSC_NSLOT; s++)
            slot_mem[s] <= '0;
      end
      else if (accept && is_save)
         slot_mem[slot_addr] <= save_src;
   end

   for (genvar i = 0; i < NCH; i++)
   begin : g_chan
      lsc_chan_t ch_reg;
      lsc_chan_t ch_next;
      logic [31:0] sp_reg;
      logic sink_reg;
      wire hit = accept && (cmd.all_channel_prefix || (32'(cmd.chan) == i));
      wire logic [31:0] meas = MEAS_UV[i*32 +: 32];
      wire logic [31:0] start_uv = 32'(start_reg) * LSC_STEP_UV;
      wire logic [31:0] stop_uv = 32'(stop_reg) * LSC_STEP_UV;
      wire logic [31:0] cur_lo = ch_reg.lvl[lvl_mode][0];
      wire logic [31:0] cur_hi = ch_reg.lvl[lvl_mode][1];

      always_comb
      begin
         ch_next = ch_reg;
         if (hit)
         begin
            case (cmd.op)
               OP_LEVEL_CURRENT, OP_LEVEL_RESISTANCE, OP_LEVEL_VOLTAGE, OP_LEVEL_POWER:
               begin
                  if (cmd.high)
                     ch_next.lvl[lvl_mode][1] = (val_fs < cur_lo) ? cur_lo : val_fs;
                  else
                     ch_next.lvl[lvl_mode][0] = (val_fs > cur_hi) ? cur_hi : val_fs;
               end
               OP_LOAD: ch_next.load_on = cmd.arg[0];
               OP_HIGH_LOW_SELECT: ch_next.high_sel = cmd.arg[0];
               OP_SHOW_PROGRAMMED_SETTING: ch_next.show_prog = cmd.arg[0];
               OP_RESTORE_SAVED_STATE_COMMAND: ch_next = slot_rd;
               default: ch_next = ch_reg;
            endcase
         end
      end

      always_ff @(posedge SYS_CLK)
      begin
         if (RST)
         begin
            ch_reg <= '0;
            sp_reg <= '0;
            sink_reg <= 1'b0;
         end
         else
         begin
            ch_reg <= ch_next;
            sp_reg <= ch_reg.lvl[mode_reg][ch_reg.high_sel];
            // hysteresis: between the two thresholds the state is held
            if (!ch_reg.load_on)
               sink_reg <= 1'b0;
            else if (meas > start_uv)
               sink_reg <= 1'b1;
            else if (meas < stop_uv)
               sink_reg <= 1'b0;
         end
      end

      assign chan_all[i] = ch_reg;
      assign SETPOINT[i*32 +: 32] = sp_reg;
      assign LOAD_ON[i] = ch_reg.load_on;
      assign SINK_ACTIVE[i] = sink_reg;
      assign SHOW_PROGRAMMED[i] = ch_reg.show_prog;
   end

   assign MODE = mode_reg;

   wire rd_status = S_AXI_ARADDR == LSC_ADDR_STATUS;
   wire rd_sink = S_AXI_ARADDR == LSC_ADDR_SINK;
   wire rd_thresh = S_AXI_ARADDR == LSC_ADDR_THRESH;
   wire rd_cmd = S_AXI_ARADDR == LSC_ADDR_CMD;
   wire rd_value = S_AXI_ARADDR == LSC_ADDR_VALUE;
   wire rd_hit = rd_status || rd_sink || rd_thresh || rd_cmd || rd_value;
   wire logic [31:0] rd_mux = rd_status ? (32'(err_reg) | (32'(trip_reg) << LSC_ST_TRIP_LSB) |
      (32'(mode_reg) << LSC_ST_MODE_LSB)) :
      rd_sink ? (32'(SINK_ACTIVE) | (32'(LOAD_ON) << LSC_SINK_LOAD_LSB)) :
      rd_thresh ? (32'(start_reg) | (32'(stop_reg) << LSC_TH_STOP_LSB)) :
      rd_cmd ? cmd_reg : rd_value ? value_reg : 32'h00000000;

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg <= LSC_RESP_OKAY;
         rdata_reg <= '0;
      end
      else if (S_AXI_ARVALID && !rvalid_reg)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_hit ? LSC_RESP_OKAY : LSC_RESP_SLVERR;
         rdata_reg <= rd_mux;
      end
      else if (S_AXI_RREADY)
         rvalid_reg <= 1'b0;
   end

   property p_no_point;
      @(posedge SYS_CLK) disable iff (RST)
      exec && no_point |=> err_reg[LSC_ERR_NO_POINT] && $stable(chan_all);
   endproperty
   a_no_point: assert property (p_no_point) else $error("level without point was executed");

   property p_reject_keeps;
      @(posedge SYS_CLK) disable iff (RST)
      exec && rejected |=> $stable(chan_all) && $stable(mode_reg) && $stable(start_reg) && $stable(stop_reg);
   endproperty
   a_reject_keeps: assert property (p_reject_keeps) else $error("rejected command changed settings");

   property p_order;
      @(posedge SYS_CLK) disable iff (RST)
      chan_all[0].lvl[0][1] >= chan_all[0].lvl[0][0];
   endproperty
   a_order: assert property (p_order) else $error("high level below low level");

   property p_full_scale;
      @(posedge SYS_CLK) disable iff (RST)
      chan_all[0].lvl[CONSTANT_CURRENT_MODE][1] <= FS_CURR;
   endproperty
   a_full_scale: assert property (p_full_scale) else $error("current above full scale");

   property p_thresh_range;
      @(posedge SYS_CLK) disable iff (RST)
      start_reg >= LSC_TENTHS_MIN && start_reg <= LSC_TENTHS_MAX && stop_reg >= LSC_TENTHS_MIN;
   endproperty
   a_thresh_range: assert property (p_thresh_range) else $error("start threshold out of range");

   property p_stop_le_start;
      @(posedge SYS_CLK) disable iff (RST)
      accept && is_stop |=> stop_reg <= start_reg && stop_reg == $past(tenths[7:0]);
   endproperty
   a_stop_le_start: assert property (p_stop_le_start) else $error("stop threshold wrong");

   property p_sink_start;
      @(posedge SYS_CLK) disable iff (RST)
      LOAD_ON[0] && (MEAS_UV[31:0] > 32'(start_reg) * LSC_STEP_UV) |=> SINK_ACTIVE[0];
   endproperty
   a_sink_start: assert property (p_sink_start) else $error("sink did not start");

   property p_sink_stop;
      @(posedge SYS_CLK) disable iff (RST)
      (MEAS_UV[31:0] < 32'(stop_reg) * LSC_STEP_UV) && !(MEAS_UV[31:0] > 32'(start_reg) * LSC_STEP_UV)
         |=> !SINK_ACTIVE[0];
   endproperty
   a_sink_stop: assert property (p_sink_stop) else $error("sink did not stop");

   property p_wipe;
      @(posedge SYS_CLK) disable iff (RST)
      wipe && TRIP_EVENT == 8'h00 |=> err_reg == 8'h00 && trip_reg == 8'h00;
   endproperty
   a_wipe: assert property (p_wipe) else $error("status bytes not cleared");

   property p_mode;
      @(posedge SYS_CLK) disable iff (RST)
      accept && cmd.op == OP_MODE |=> MODE == $past(cmd.arg[1:0]) ##1 $stable(MODE) || $past(accept);
   endproperty
   a_mode: assert property (p_mode) else $error("mode not applied");

   property p_setpoint;
      @(posedge SYS_CLK) disable iff (RST)
      $stable(chan_all[0]) && $stable(mode_reg) |-> SETPOINT[31:0] == chan_all[0].lvl[mode_reg][chan_all[0].high_sel];
   endproperty
   a_setpoint: assert property (p_setpoint) else $error("setpoint not following selection");

   property p_restore;
      @(posedge SYS_CLK) disable iff (RST)
      accept && is_restore && (cmd.all_channel_prefix || cmd.chan == 3'h0) |=> chan_all[0] == $past(slot_rd);
   endproperty
   a_restore: assert property (p_restore) else $error("restore did not load slot");
endmodule : lsc_engine

// [lsc_host.sv]
// Purpose: host model issuing register accesses to the load engine
// Assumes: caller enters a task just after a rising edge, one access at a time
// Notes: tmo rises when an answer never comes
`timescale 1ns/10ps
module lsc_host
   import lsc_pkg::*;
(
   input wire logic clk,
   output logic [LSC_AW-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [LSC_AW-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready,
   output logic tmo
);
   // text framing is stripped before this bus, one word per command
   initial
   begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, tmo} = '0;
      wstrb = LSC_STRB_ALL;
   end

   task automatic wr(input logic [LSC_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      while (!bvalid && n < 64);
      r = bresp;
      bready <= 1'b0;
      if (n >= 64) tmo <= 1'b1;
   endtask : wr

   task automatic rd(input logic [LSC_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end
      while (!rvalid && n < 64);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 64) tmo <= 1'b1;
   endtask : rd
endmodule : lsc_host

// [tb_top.sv]
// Purpose: self-checking bench of the load setting command engine
// Assumes: default parameters, eight channels
// Notes: commands are VALUE then CMD writes through the host model
`timescale 1ns/10ps
module tb_top
   import lsc_pkg::*;
   ;
   localparam logic [6:0] PT = 7'h02;
   localparam logic [6:0] HI = 7'h03;
   localparam logic [6:0] PRE = 7'h04;
   logic clk, rst, tmo;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [LSC_AW-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r, mode;
   logic [255:0] meas, setp;
   logic [7:0] trip, load_on, sink, showp;
   int failures = 0;
   int samples_checked = 0;

   lsc_host i_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .tmo(tmo));
   lsc_engine i_dut (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MEAS_UV(meas),
      .TRIP_EVENT(trip), .SETPOINT(setp), .MODE(mode), .LOAD_ON(load_on), .SINK_ACTIVE(sink),
      .SHOW_PROGRAMMED(showp));

   initial clk = 1'b0;
   always #10 clk = ~clk;

   // flags: serial, channel, prefix, point, high
   function automatic logic [31:0] cw(input lsc_op_t op, input logic [6:0] f, input logic [3:0] a,
      input logic [3:0] m, input logic [4:0] n);
      return {7'h00, n, m, a, f, op};
   endfunction : cw

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rdc(input logic [LSC_AW-1:0] a, input logic [31:0] e);
      i_host.rd(a, v, r);
      chk(v, e);
   endtask : rdc

   // setpoint lags state by one cycle, hence the two edges
   task automatic run(input logic [31:0] val, input logic [31:0] c);
      i_host.wr(LSC_ADDR_VALUE, val, r);
      i_host.wr(LSC_ADDR_CMD, c, r);
      repeat (2) @(posedge clk);
   endtask : run

   task automatic stop_test();
      if (tmo === 1'b1) failures++;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   always @(posedge tmo) stop_test();

   initial
   begin
      rst = 1'b1;
      meas = '0;
      trip = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc(LSC_ADDR_THRESH, 32'h0000050a);
      rdc(LSC_ADDR_STATUS, 32'h00000000);
      $display("reset test done");
      run(32'd1500000, cw(OP_LEVEL_CURRENT, 7'h00, 4'h0, 4'h0, 5'h00));
      rdc(LSC_ADDR_STATUS, 32'h00000001);
      chk(setp[31:0], 32'h0);
      // high first: a low above the stored high is pulled down to it
      run(32'd2123456, cw(OP_LEVEL_CURRENT, HI, 4'h0, 4'h0, 5'h00));
      run(32'd0, cw(OP_HIGH_LOW_SELECT, 7'h00, 4'h1, 4'h0, 5'h00));
      chk(setp[31:0], 32'd2123456);
      run(32'd3000000, cw(OP_LEVEL_CURRENT, 7'h42, 4'h0, 4'h0, 5'h00));
      run(32'hffffffff, cw(OP_LEVEL_CURRENT, HI, 4'h0, 4'h0, 5'h00));
      chk(setp[31:0], 32'h03938700);
      run(32'd0, cw(OP_HIGH_LOW_SELECT, 7'h00, 4'h0, 4'h0, 5'h00));
      chk(setp[31:0], 32'd2123456);
      rdc(LSC_ADDR_CMD, cw(OP_HIGH_LOW_SELECT, 7'h00, 4'h0, 4'h0, 5'h00));
      $display("level test done");
      run(32'd0, cw(OP_LOAD, PRE, 4'h1, 4'h0, 5'h00));
      chk({24'h0, load_on}, 32'h000000ff);
      run(32'd0, cw(OP_LOAD, 7'h18, 4'h0, 4'h0, 5'h00));
      chk({24'h0, load_on}, 32'h000000f7);
      run(32'd2500000, cw(OP_SINK_START_VOLTAGE, PT, 4'h0, 4'h0, 5'h00));
      run(32'd3000000, cw(OP_SINK_STOP_VOLTAGE, PT, 4'h0, 4'h0, 5'h00));
      rdc(LSC_ADDR_THRESH, 32'h00000519);
      run(32'd2000000, cw(OP_SINK_STOP_VOLTAGE, PT, 4'h0, 4'h0, 5'h00));
      rdc(LSC_ADDR_THRESH, 32'h00001419);
      rdc(LSC_ADDR_STATUS, 32'h00000003);
      meas[31:0] <= 32'd3000000;
      repeat (3) @(posedge clk);
      chk({24'h0, sink}, 32'h00000001);
      meas[31:0] <= 32'd2200000;
      repeat (3) @(posedge clk);
      chk({24'h0, sink}, 32'h00000001);
      meas[31:0] <= 32'd1500000;
      repeat (3) @(posedge clk);
      chk({24'h0, sink}, 32'h00000000);
      $display("load test done");
      for (int k = 0; k < 4; k++)
      begin
         run(32'd0, cw(OP_MODE, 7'h00, k[3:0], 4'h0, 5'h00));
         chk({30'h0, mode}, k[31:0]);
      end
      run(32'd0, cw(OP_MODE, 7'h00, 4'h4, 4'h0, 5'h00));
      rdc(LSC_ADDR_STATUS, 32'h00030007);
      run(32'd0, cw(OP_HIGH_LOW_SELECT, 7'h00, 4'h1, 4'h0, 5'h00));
      run(32'd7000000, cw(OP_LEVEL_POWER, HI, 4'h0, 4'h0, 5'h00));
      chk(setp[31:0], 32'd7000000);
      run(32'd0, cw(OP_SHOW_PROGRAMMED_SETTING, PRE, 4'h1, 4'h0, 5'h00));
      chk({24'h0, showp}, 32'h000000ff);
      run(32'd0, cw(OP_SHOW_PROGRAMMED_SETTING, 7'h00, 4'h0, 4'h0, 5'h00));
      chk({24'h0, showp}, 32'h000000fe);
      $display("mode test done");
      run(32'd0, cw(OP_SAVE_STATE_COMMAND, 7'h00, 4'h0, 4'h2, 5'h1e));
      run(32'd9000000, cw(OP_LEVEL_POWER, HI, 4'h0, 4'h0, 5'h00));
      chk(setp[31:0], 32'd9000000);
      run(32'd0, cw(OP_RESTORE_SAVED_STATE_COMMAND, 7'h00, 4'h0, 4'h1, 5'h01));
      chk(setp[31:0], 32'h0);
      chk({24'h0, load_on}, 32'h000000f6);
      run(32'd0, cw(OP_RESTORE_SAVED_STATE_COMMAND, 7'h00, 4'h0, 4'h2, 5'h1e));
      chk(setp[31:0], 32'd7000000);
      chk({24'h0, load_on}, 32'h000000f7);
      $display("memory test done");
      trip <= 8'h04;
      @(posedge clk);
      trip <= 8'h00;
      i_host.rd(LSC_ADDR_STATUS, v, r);
      chk({31'h0, |v[15:8]}, 32'h1);
      run(32'd0, cw(OP_STATUS_WIPE_COMMAND, 7'h00, 4'h0, 4'h0, 5'h00));
      rdc(LSC_ADDR_STATUS, 32'h00030000);
      i_host.wr(8'h14, 32'h1, r);
      chk({30'h0, r}, {30'h0, LSC_RESP_SLVERR});
      i_host.wr(LSC_ADDR_THRESH, 32'h0, r);
      chk({30'h0, r}, {30'h0, LSC_RESP_SLVERR});
      rdc(LSC_ADDR_THRESH, 32'h00001419);
      i_host.rd(8'h14, v, r);
      chk({v[29:0], r}, {30'h0, LSC_RESP_SLVERR});
      $display("status test done");
      stop_test();
   end
endmodule : tb_top
